//--- src/lic_regs.vh
// Purpose: register map and field constants of the local interrupt controller
// Assumes: AXI4-Lite slave, 32-bit data, one aligned word per register
// Notes: Behaviour
// Behaviour
// - disable keeps registers, forces all table masks
// - disabled accepts only startup reset, sysmgmt, nmi, start
// - nmi and startup reset forced edge, except deassert
// - command-register messages always edge, except reset deassert
// - logical destination holds eight-bit identifier
// - earlier generation identifier is four bits
// - later generation identifier is eight bits
// - later generation rejects remote-read delivery
// - lowest-priority arbitration only with free slot
// - logical mode supports cluster addressing
// - focus checking enabled by software bit
// - polarity of both local pins programmable
// - sysmgmt message via command register or redirection
// - error status register reports through table entry
// - table entry for performance counter interrupts
// - later generation adds thermal table entry
// - later generation never redirects to focus
// - later generation lacks flat cluster mode
// - nmi blocked until first interrupt return
`ifndef LIC_REGS_VH
`define LIC_REGS_VH
`define LIC_OFS_ID 12'h020
`define LIC_OFS_LDEST 12'h0D0
`define LIC_OFS_DFMT 12'h0E0
`define LIC_OFS_SPUR 12'h0F0
`define LIC_OFS_ESR 12'h280
`define LIC_OFS_CMD 12'h300
`define LIC_OFS_STAT 12'h310
`define LIC_OFS_THERM 12'h330
`define LIC_OFS_PERF 12'h340
`define LIC_OFS_PINA 12'h350
`define LIC_OFS_PINB 12'h360
`define LIC_OFS_ERR 12'h370
`define LIC_ID_POS 24
`define LIC_LDEST_POS 24
`define LIC_SPUR_EN_BIT 8
`define LIC_SPUR_FOCUS_BIT 9
`define LIC_MASK_BIT 16
`define LIC_TRIG_BIT 15
`define LIC_POL_BIT 13
`define LIC_LEVEL_BIT 14
`define LIC_DM_POS 8
`define LIC_DFMT_FLAT 4'hF
`define LIC_DFMT_CLUSTER 4'h0
`define LIC_DM_FIXED 3'h0
`define LIC_DM_LOWEST 3'h1
`define LIC_DM_SMI 3'h2
`define LIC_DM_RREAD 3'h3
`define LIC_DM_NMI 3'h4
`define LIC_DM_INIT 3'h5
`define LIC_DM_START 3'h6
`define LIC_LVT_RESET 32'h0001_0000
`define LIC_DFMT_RESET 32'hFFFF_FFFF
`define LIC_SPUR_RESET 32'h0000_00FF
`define LIC_ESR_ILLDM 7
`define LIC_ESR_RXACC 6
`endif

//--- src/lic_ctrl.v
// Purpose: local interrupt controller with AXI4-Lite register access
// Assumes: one clock mclk, synchronous active-high rst
// Notes: message port carries one incoming interprocessor message per pulse
`timescale 1ns/1ns
`include "lic_regs.vh"
module lic_ctrl #(
  parameter GEN = 1,
  parameter SLOTS = 2
) (
  // clock and reset
  input wire mclk,
  input wire rst,
  // axi4-lite write address
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // incoming interprocessor message
  input wire msg_valid,
  input wire [2:0] msg_mode,
  input wire msg_logical,
  input wire msg_deassert,
  input wire msg_level,
  input wire [7:0] msg_dest,
  input wire [7:0] msg_vector,
  // local sources
  input wire local_interrupt_pin_a,
  input wire local_interrupt_pin_b,
  input wire perf_event,
  input wire thermal_event,
  input wire core_interrupt_return_instruction,
  input wire core_ack,
  // outgoing message from the command register
  output reg out_valid,
  output reg [2:0] out_mode,
  output reg out_level,
  output reg [7:0] out_dest,
  output reg [7:0] out_vector,
  // delivery to the core
  output reg core_int,
  output reg [7:0] core_vector,
  output reg core_nmi,
  output reg core_smi,
  output reg core_init,
  output reg core_start,
  output reg arb_join,
  output reg focus_hit
);

  localparam IDW = (GEN == 0) ? 4 : 8;
  localparam NTAB = 5;
  localparam [IDW-1:0] ID_RESET = {IDW{1'b0}};

  // ********************************
  // registers
  // ********************************
  reg [IDW-1:0] id_reg;
  reg [7:0] ldest_reg;
  reg [31:0] dfmt_reg;
  reg [31:0] spur_reg;
  reg [7:0] esr_reg;
  reg [31:0] cmd_reg;
  reg [31:0] tab_reg [0:NTAB-1];
  reg [1:0] busy_reg;
  reg nmi_blk_reg;
  reg pina_d_reg;
  reg pinb_d_reg;
  reg perf_d_reg;
  reg therm_d_reg;
  reg [7:0] esr_d_reg;
  reg aw_have_reg;
  reg w_have_reg;
  reg [11:0] aw_reg;
  reg [31:0] wd_reg;
  reg [3:0] ws_reg;

  wire sw_en = spur_reg[`LIC_SPUR_EN_BIT];
  wire flat = (dfmt_reg[31:28] == `LIC_DFMT_FLAT);
  wire free_slot = (busy_reg < SLOTS);

  // table index by offset; returns NTAB when not a table register
  function [2:0] tab_idx;
    input [11:0] a;
    begin
      case (a)
        `LIC_OFS_THERM: tab_idx = 3'd0;
        `LIC_OFS_PERF: tab_idx = 3'd1;
        `LIC_OFS_PINA: tab_idx = 3'd2;
        `LIC_OFS_PINB: tab_idx = 3'd3;
        `LIC_OFS_ERR: tab_idx = 3'd4;
        default: tab_idx = 3'd5;
      endcase
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] st;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (st[k]) merge[k*8 +: 8] = nw[k*8 +: 8];
      end
    end
  endfunction

  // ********************************
  // destination match
  // ********************************
  reg dest_hit;
  always @* begin
    dest_hit = 1'b0;
    if (!msg_logical) begin
      dest_hit = (msg_dest[IDW-1:0] == id_reg);
    end else if (flat) begin
      dest_hit = |(msg_dest & ldest_reg);
    end else begin
      dest_hit = (msg_dest[7:4] == ldest_reg[7:4]) &&
        |(msg_dest[3:0] & ldest_reg[3:0]);
    end
  end

  // ********************************
  // message acceptance
  // ********************************
  reg mode_ok;
  reg accept;
  always @* begin
    mode_ok = 1'b1;
    if (msg_mode == `LIC_DM_RREAD && GEN != 0) mode_ok = 1'b0;
    if (msg_mode == 3'h7) mode_ok = 1'b0;
    if (msg_logical && flat && GEN != 0) mode_ok = 1'b0;
    accept = msg_valid && dest_hit && mode_ok;
    if (!sw_en && !(msg_mode == `LIC_DM_INIT ||
        msg_mode == `LIC_DM_SMI || msg_mode == `LIC_DM_NMI ||
        msg_mode == `LIC_DM_START)) accept = 1'b0;
  end

  wire is_fixed = (msg_mode == `LIC_DM_FIXED) ||
    (msg_mode == `LIC_DM_LOWEST);
  wire lowest = accept && msg_mode == `LIC_DM_LOWEST;
  // nmi and init assert are edge even when programmed level; init deassert keeps msg_level
  wire edge_forced = (msg_mode == `LIC_DM_NMI) ||
    (msg_mode == `LIC_DM_INIT && !msg_deassert);
  wire eff_level = msg_level && !edge_forced;

  // ********************************
  // local pin and event edges
  // ********************************
  wire pina_act = local_interrupt_pin_a ^
    tab_reg[2][`LIC_POL_BIT];
  wire pinb_act = local_interrupt_pin_b ^
    tab_reg[3][`LIC_POL_BIT];
  wire pina_rise = pina_act && !pina_d_reg;
  wire pinb_rise = pinb_act && !pinb_d_reg;
  wire perf_rise = perf_event && !perf_d_reg;
  wire therm_rise = (GEN != 0) && thermal_event && !therm_d_reg;
  wire err_rise = (esr_reg != 8'h00) && (esr_d_reg == 8'h00);

  // ********************************
  // axi4-lite slave
  // ********************************
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire [11:0] waddr = aw_have_reg ? aw_reg : s_axi_awaddr;
  wire [31:0] wdata = w_have_reg ? wd_reg : s_axi_wdata;
  wire [3:0] wstrb = w_have_reg ? ws_reg : s_axi_wstrb;
  wire wr_go = (aw_have_reg || aw_take) && (w_have_reg || w_take) &&
    !s_axi_bvalid;
  wire [2:0] wtab = tab_idx(waddr);
  wire [2:0] rtab = tab_idx(s_axi_araddr);
  wire wr_known = (wtab != 3'd5) || waddr == `LIC_OFS_ID ||
    waddr == `LIC_OFS_LDEST || waddr == `LIC_OFS_DFMT ||
    waddr == `LIC_OFS_SPUR || waddr == `LIC_OFS_ESR ||
    waddr == `LIC_OFS_CMD;

  reg [31:0] rd_next;
  reg rd_ok;
  always @* begin
    rd_ok = 1'b1;
    rd_next = 32'h0000_0000;
    if (rtab != 3'd5 && !(rtab == 3'd0 && GEN == 0)) begin
      rd_next = tab_reg[rtab];
    end else begin
      case (s_axi_araddr)
        `LIC_OFS_ID: rd_next[`LIC_ID_POS +: IDW] = id_reg;
        `LIC_OFS_LDEST: rd_next[`LIC_LDEST_POS +: 8] = ldest_reg;
        `LIC_OFS_DFMT: rd_next = dfmt_reg;
        `LIC_OFS_SPUR: rd_next = spur_reg;
        `LIC_OFS_ESR: rd_next = {24'h000000, esr_reg};
        `LIC_OFS_CMD: rd_next = cmd_reg;
        `LIC_OFS_STAT: rd_next = {28'h0000000, nmi_blk_reg,
          free_slot, busy_reg};
        default: rd_ok = 1'b0;
      endcase
    end
  end

  // ********************************
  // main sequential logic
  // ********************************
  integer i;
  always @(posedge mclk) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0000_0000;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_reg <= 12'h000;
      wd_reg <= 32'h0000_0000;
      ws_reg <= 4'h0;
      id_reg <= ID_RESET;
      ldest_reg <= 8'h00;
      dfmt_reg <= `LIC_DFMT_RESET;
      spur_reg <= `LIC_SPUR_RESET;
      esr_reg <= 8'h00;
      esr_d_reg <= 8'h00;
      cmd_reg <= 32'h0000_0000;
      for (i = 0; i < NTAB; i = i + 1) tab_reg[i] <= `LIC_LVT_RESET;
      busy_reg <= 2'h0;
      nmi_blk_reg <= 1'b0;
      pina_d_reg <= 1'b0;
      pinb_d_reg <= 1'b0;
      perf_d_reg <= 1'b0;
      therm_d_reg <= 1'b0;
      out_valid <= 1'b0;
      out_mode <= 3'h0;
      out_level <= 1'b0;
      out_dest <= 8'h00;
      out_vector <= 8'h00;
      core_int <= 1'b0;
      core_vector <= 8'h00;
      core_nmi <= 1'b0;
      core_smi <= 1'b0;
      core_init <= 1'b0;
      core_start <= 1'b0;
      arb_join <= 1'b0;
      focus_hit <= 1'b0;
    end else begin
      pina_d_reg <= pina_act;
      pinb_d_reg <= pinb_act;
      perf_d_reg <= perf_event;
      therm_d_reg <= thermal_event;
      esr_d_reg <= esr_reg;
      out_valid <= 1'b0;
      core_int <= 1'b0;
      core_nmi <= 1'b0;
      core_smi <= 1'b0;
      core_init <= 1'b0;
      core_start <= 1'b0;
      arb_join <= lowest && free_slot;
      focus_hit <= lowest && free_slot && GEN == 0 &&
        spur_reg[`LIC_SPUR_FOCUS_BIT] && sw_en;
      // write channel
      s_axi_awready <= !aw_have_reg && !aw_take && !s_axi_bvalid;
      s_axi_wready <= !w_have_reg && !w_take && !s_axi_bvalid;
      if (aw_take) aw_reg <= s_axi_awaddr;
      if (w_take) begin
        wd_reg <= s_axi_wdata;
        ws_reg <= s_axi_wstrb;
      end
      aw_have_reg <= (aw_have_reg || aw_take) && !wr_go;
      w_have_reg <= (w_have_reg || w_take) && !wr_go;
      if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? 2'h0 : 2'h2;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        if (wtab != 3'd5) tab_reg[wtab] <= merge(tab_reg[wtab], wdata, wstrb);
        case (waddr)
          `LIC_OFS_ID: if (wstrb[3]) id_reg <= wdata[`LIC_ID_POS +: IDW];
          `LIC_OFS_LDEST: if (wstrb[3]) ldest_reg <= wdata[31:24];
          `LIC_OFS_DFMT: if (GEN == 0 && wstrb[3])
            dfmt_reg <= {wdata[31:28], 28'hFFFFFFF};
          `LIC_OFS_SPUR: spur_reg <= merge(spur_reg, wdata, wstrb);
          `LIC_OFS_ESR: esr_reg <= 8'h00;
          `LIC_OFS_CMD: begin
            cmd_reg <= merge(cmd_reg, wdata, wstrb);
            out_valid <= 1'b1;
            out_mode <= wdata[`LIC_DM_POS +: 3];
            out_vector <= wdata[7:0];
            out_dest <= wdata[31:24];
            // command-register sends are edge unless init deassert
            out_level <= wdata[`LIC_DM_POS +: 3] == `LIC_DM_INIT &&
              !wdata[`LIC_LEVEL_BIT] && wdata[`LIC_TRIG_BIT];
          end
          default: ;
        endcase
      end
      // disable forces every table mask, nothing else changes
      if (!sw_en) begin
        for (i = 0; i < NTAB; i = i + 1)
          tab_reg[i][`LIC_MASK_BIT] <= 1'b1;
      end
      // read channel
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_rvalid && s_axi_rready) s_axi_rvalid <= 1'b0;
      if (s_axi_arready && s_axi_arvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_next;
        s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
      end
      // slot count: set and release in same cycle cancel, count holds
      if (accept && is_fixed && !eff_level && free_slot && !core_ack)
        busy_reg <= busy_reg + 2'h1;
      else if (core_ack && busy_reg != 2'h0 &&
          !(accept && is_fixed && free_slot))
        busy_reg <= busy_reg - 2'h1;
      // nmi block until interrupt return; an nmi in the return cycle is still blocked
      if (core_interrupt_return_instruction) nmi_blk_reg <= 1'b0;
      if (accept && msg_mode == `LIC_DM_NMI && !nmi_blk_reg) begin
        core_nmi <= 1'b1;
        nmi_blk_reg <= 1'b1;
      end
      if (accept && msg_mode == `LIC_DM_SMI) core_smi <= 1'b1;
      if (accept && msg_mode == `LIC_DM_INIT && !msg_deassert)
        core_init <= 1'b1;
      if (accept && msg_mode == `LIC_DM_START) core_start <= 1'b1;
      if (accept && is_fixed && free_slot &&
          (msg_mode == `LIC_DM_FIXED || GEN != 0 || !focus_hit)) begin
        core_int <= 1'b1;
        core_vector <= msg_vector;
      // local table entries, lowest index first
      end else if (therm_rise && !tab_reg[0][`LIC_MASK_BIT]) begin
        core_int <= 1'b1;
        core_vector <= tab_reg[0][7:0];
      end else if (perf_rise && !tab_reg[1][`LIC_MASK_BIT]) begin
        core_int <= 1'b1;
        core_vector <= tab_reg[1][7:0];
      end else if (pina_rise && !tab_reg[2][`LIC_MASK_BIT]) begin
        core_int <= 1'b1;
        core_vector <= tab_reg[2][7:0];
      end else if (pinb_rise && !tab_reg[3][`LIC_MASK_BIT]) begin
        core_int <= 1'b1;
        core_vector <= tab_reg[3][7:0];
      end else if (err_rise && !tab_reg[4][`LIC_MASK_BIT]) begin
        core_int <= 1'b1;
        core_vector <= tab_reg[4][7:0];
      end
      // error log: hardware set wins over software clear
      if (msg_valid && dest_hit && !mode_ok)
        esr_reg[`LIC_ESR_ILLDM] <= 1'b1;
      if (accept && is_fixed && !free_slot)
        esr_reg[`LIC_ESR_RXACC] <= 1'b1;
    end
  end

endmodule // lic_ctrl

//--- tb/lic_ctrl_assertions.sv
// Purpose: port checks of the local interrupt controller
// Assumes: one clock, synchronous active-high reset
// Notes: nmi blocking tracked from core_nmi and core_interrupt_return_instruction
`timescale 1ns/1ns
module lic_ctrl_checker #(parameter GEN = 1) (
  // clock, reset and incoming message
  input wire mclk,
  input wire rst,
  input wire msg_valid,
  input wire [2:0] msg_mode,
  input wire msg_deassert,
  // core side and command output
  input wire core_interrupt_return_instruction,
  input wire core_nmi,
  input wire core_smi,
  input wire core_init,
  input wire core_start,
  input wire arb_join,
  input wire focus_hit,
  input wire out_valid,
  input wire out_level,
  input wire [2:0] out_mode
);
  reg nblk_reg;
  always @(posedge mclk) begin
    if (rst)
      nblk_reg <= 1'b0;
    else if (core_nmi)
      nblk_reg <= 1'b1;
    else if (core_interrupt_return_instruction)
      nblk_reg <= 1'b0;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ********************
  // assertions
  // ********************
  nmi_block_a: assert property (core_nmi |-> !nblk_reg)
    else $error("nmi delivered while blocked");
  nmi_answer_a: assert property (msg_valid && msg_mode == 3'h4 &&
    !nblk_reg && !core_nmi |=> core_nmi) else $error("nmi not delivered");
  smi_answer_a: assert property (msg_valid && msg_mode == 3'h2
    |=> core_smi) else $error("smi not delivered");
  init_answer_a: assert property (msg_valid && msg_mode == 3'h5 &&
    !msg_deassert |=> core_init) else $error("init not delivered");
  start_answer_a: assert property (msg_valid && msg_mode == 3'h6
    |=> core_start) else $error("start not delivered");
  rread_refuse_a: assert property (msg_valid && msg_mode == 3'h3 &&
    GEN != 0 |=> !(core_nmi || core_smi || core_init || core_start ||
    arb_join)) else $error("remote read accepted");
  focus_never_a: assert property (focus_hit |-> GEN == 0)
    else $error("focus delivery in later generation");
  cmd_edge_a: assert property (out_valid && out_level
    |-> out_mode == 3'h5) else $error("level command not init deassert");
  join_cause_a: assert property (arb_join |-> $past(msg_valid) &&
    $past(msg_mode) == 3'h1) else $error("join without lowest message");
  cover property (core_nmi);
  cover property (arb_join);
  cover property (out_valid && out_level);
endmodule // lic_ctrl_checker

//--- tb/lic_core_model.sv
// Purpose: behavioural core that retires nmi and frees slots
// Assumes: hold stalls both answers
// Notes: prompt answer one cycle after the request is seen
`timescale 1ns/1ns
module lic_core_model (
  // clock, reset and stall
  input wire mclk,
  input wire rst,
  input wire hold,
  // controller side
  input wire core_int,
  input wire core_nmi,
  output reg core_interrupt_return_instruction,
  output reg core_ack
);
  reg nmi_reg;
  reg [3:0] busy_reg;
  always @(posedge mclk) begin
    core_interrupt_return_instruction <= 1'b0;
    core_ack <= 1'b0;
    if (rst) begin
      nmi_reg <= 1'b0;
      busy_reg <= 4'h0;
    end else begin
      if (core_nmi)
        nmi_reg <= 1'b1;
      else if (nmi_reg && !hold) begin
        nmi_reg <= 1'b0;
        core_interrupt_return_instruction <= 1'b1;
      end
      if (core_int)
        busy_reg <= busy_reg + 4'h1;
      else if (busy_reg != 4'h0 && !hold) begin
        busy_reg <= busy_reg - 4'h1;
        core_ack <= 1'b1;
      end
    end
  end
endmodule // lic_core_model

//--- tb/tb_local_interrupt_controller.sv
// Purpose: self-checking bench of the local interrupt controller
// Assumes: later generation, two slots
// Notes: drivers queue expectations, one monitor compares
`timescale 1ns/1ns
`include "lic_regs.vh"
module tb_local_interrupt_controller;
  reg mclk, rst, hold, msg_valid, msg_logical, msg_level, msg_deassert;
  reg s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  reg s_axi_rready, perf_event, thermal_event;
  reg local_interrupt_pin_a, local_interrupt_pin_b;
  reg [11:0] s_axi_awaddr, s_axi_araddr;
  reg [31:0] s_axi_wdata;
  reg [3:0] s_axi_wstrb;
  reg [2:0] msg_mode;
  reg [7:0] msg_vector, msg_dest, v;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, out_valid, out_level, core_int, core_nmi, core_smi;
  wire core_init, core_start, arb_join, focus_hit, core_interrupt_return_instruction, core_ack;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [2:0] out_mode;
  wire [7:0] out_dest, out_vector, core_vector;
  wire [13:0] ev = {core_int ? core_vector : 8'h00, arb_join, core_int,
    core_nmi, core_smi, core_init, core_start};
  logic [33:0] rq[$], bq[$], eq[$], oq[$];
  integer miscompares, checks, cyc, i;
  lic_ctrl #(.GEN(1), .SLOTS(2)) dut (.*);
  lic_core_model core (.*);
  always #5 mclk = ~mclk;
  // ********************
  // compare, bus and message tasks
  // ********************
  task cmp(input [33:0] e, input [33:0] g);
    begin
      checks = checks + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
      end
    end
  endtask
  task wr(input [11:0] a, input [31:0] d, input [1:0] r);
    reg done;
    begin
      @(posedge mclk);
      bq.push_back({32'h0, r});
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      done = 0;
      while (!done) begin
        @(posedge mclk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        done = s_axi_bvalid;
      end
      s_axi_bready <= 1'b0;
    end
  endtask
  task rd(input [11:0] a, input [31:0] d);
    reg done;
    begin
      @(posedge mclk);
      rq.push_back({2'b00, d});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      done = 0;
      while (!done) begin
        @(posedge mclk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
        done = s_axi_rvalid;
      end
      s_axi_rready <= 1'b0;
    end
  endtask
  task msg(input [2:0] m, input l, input [5:0] f);
    begin
      @(posedge mclk);
      v = 8'($urandom);
      msg_valid <= 1'b1;
      msg_mode <= m;
      msg_logical <= l;
      // level only for nmi and init, whose trigger mode is forced to edge except on init deassert
      msg_level <= (m == 3'h4 || m == 3'h5) ? 1'($urandom) : 1'b0;
      msg_vector <= v;
      if (f != 6'h00) eq.push_back({20'h0, f[4] ? v : 8'h00, f});
      @(posedge mclk);
      msg_valid <= 1'b0;
    end
  endtask
  task give_verdict;
    begin
      if (rq.size() + bq.size() + eq.size() + oq.size() != 0)
        miscompares = miscompares + 1;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares = miscompares + 1;
      give_verdict;
    end
    if (!rst && ev != 14'h0)
      cmp(eq.pop_front(), {20'h0, ev});
    if (s_axi_rvalid && s_axi_rready)
      cmp(rq.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready)
      cmp(bq.pop_front(), {32'h0, s_axi_bresp});
    if (out_valid)
      cmp(oq.pop_front(), {14'h0, out_level, out_mode, out_dest,
        out_vector});
  end
  // ********************
  // main sequence
  // ********************
  initial begin
    {mclk, hold, msg_valid, msg_logical, msg_level, msg_deassert} = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 0;
    {s_axi_rready, perf_event, thermal_event} = 0;
    {local_interrupt_pin_a, local_interrupt_pin_b, msg_mode, v} = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, msg_vector} = 0;
    {miscompares, checks, cyc} = 0;
    s_axi_wstrb = 4'hF;
    msg_dest = 8'hA5;
    rst = 1'b1;
    void'($urandom(85133));
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    rd(`LIC_OFS_PINA, `LIC_LVT_RESET);
    rd(`LIC_OFS_SPUR, `LIC_SPUR_RESET);
    wr(`LIC_OFS_ID, 32'hA500_0000, 2'b00);
    rd(`LIC_OFS_ID, 32'hA500_0000);
    wr(`LIC_OFS_LDEST, 32'h2500_0000, 2'b00);
    rd(`LIC_OFS_LDEST, 32'h2500_0000);
    wr(`LIC_OFS_DFMT, 32'h0, 2'b00);
    rd(`LIC_OFS_DFMT, `LIC_DFMT_RESET);
    wr(12'h3F0, 32'h0, 2'b10);
    $display("register test done");
    for (i = 0; i < 7; i = i + 1)
      msg(i[2:0], 1'b0, i == 2 ? 6'h04 : i == 4 ? 6'h08 : i == 5 ? 6'h02 :
        i == 6 ? 6'h01 : 6'h00);
    msg_deassert <= 1'b1;
    msg(3'h5, 1'b0, 6'h00);
    msg_deassert <= 1'b0;
    $display("disabled test done");
    wr(`LIC_OFS_SPUR, 32'h0000_03FF, 2'b00);
    rd(`LIC_OFS_SPUR, 32'h0000_03FF);
    hold <= 1'b1;
    msg(3'h0, 1'b0, 6'h10);
    msg(3'h0, 1'b0, 6'h10);
    msg(3'h1, 1'b0, 6'h00);
    msg(3'h4, 1'b0, 6'h08);
    msg(3'h4, 1'b0, 6'h00);
    msg(3'h3, 1'b0, 6'h00);
    hold <= 1'b0;
    repeat (8) @(posedge mclk);
    msg(3'h1, 1'b0, 6'h30);
    msg(3'h4, 1'b0, 6'h08);
    rd(`LIC_OFS_ESR, 32'h0000_00C0);
    wr(`LIC_OFS_ESR, 32'h0, 2'b00);
    rd(`LIC_OFS_ESR, 32'h0);
    wr(`LIC_OFS_ERR, 32'h0000_0077, 2'b00);
    eq.push_back({20'h0, 8'h77, 6'h10});
    msg(3'h0, 1'b1, 6'h00);
    msg(3'h3, 1'b0, 6'h00);
    $display("message test done");
    for (i = 0; i < 7; i = i + 1) if (i != 3) begin
      v = 8'($urandom);
      oq.push_back({15'h0, i[2:0], 8'hA5, v});
      wr(`LIC_OFS_CMD, {8'hA5, 8'h00, 5'b11000, i[2:0], v}, 2'b00);
    end
    oq.push_back({14'h0, 1'b1, 3'h5, 8'hA5, 8'h00});
    wr(`LIC_OFS_CMD, 32'hA500_8500, 2'b00);
    $display("command test done");
    for (i = 0; i < 2; i = i + 1) begin
      v = 8'($urandom);
      wr(i ? `LIC_OFS_THERM : `LIC_OFS_PERF, {24'h0, v}, 2'b00);
      eq.push_back({20'h0, v, 6'h10});
      perf_event <= 1'b1;
      thermal_event <= i[0];
      repeat (4) @(posedge mclk);
    end
    wr(`LIC_OFS_SPUR, `LIC_SPUR_RESET, 2'b00);
    rd(`LIC_OFS_THERM, {16'h0001, 8'h00, v});
    rd(`LIC_OFS_LDEST, 32'h2500_0000);
    for (i = 0; i < 2; i = i + 1) begin
      wr(`LIC_OFS_PINA + 12'(16 * i), 32'h0001_2041, 2'b00);
      rd(`LIC_OFS_PINA + 12'(16 * i), 32'h0001_2041);
    end
    $display("table test done");
    repeat (20) @(posedge mclk);
    give_verdict;
  end
endmodule // tb_local_interrupt_controller
bind lic_ctrl lic_ctrl_checker #(.GEN(GEN)) chk (.*);
